// >>> hdl/fbp_flash_block_protection.sv
`timescale 1ns/1ps
// Functional notes
// - flash array of 16 KB sits behind the protection logic
// - each 1 KB unit erases alone, leaving others untouched
// - after erase every bit of the unit reads one
// - each 2 KB pair of units has its own protection setting
// - a pair can be read-only or execute-only
// - read-only pairs refuse erase and program
// - execute-only pairs refuse erase and program
// - execute-only pairs serve fetches only, block data and debug reads; src is never checked, so a fetch op from the debug port is served
module fbp_flash_block_protection
  import fbp_pkg::*;
#(
  parameter int REGION_COUNT = REGIONS
) (
  // clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  // protection settings, one bit per 2 KB pair
  input  wire logic [REGION_COUNT-1:0] i_read_only,
  input  wire logic [REGION_COUNT-1:0] i_exec_only,
  // access request
  input  wire logic                    i_req_valid,
  input  wire fbp_req_s                i_req,
  output logic                         o_req_ready,
  // answer
  output fbp_rsp_s                     o_rsp
);

  // ****************************************
  // storage and state
  // ****************************************
  logic [WORD_W-1:0]       mem [WORDS];
  fbp_state_e              state;
  fbp_state_e              next_state;
  logic [UNIT_LSB-3:0]     erase_cnt;
  logic [UNIT_LSB-3:0]     next_erase_cnt;
  logic [WADDR_W-1:0]      erase_base;
  logic [WADDR_W-1:0]      next_erase_base;
  fbp_rsp_s                rsp;
  fbp_rsp_s                next_rsp;
  logic                    wr_en;
  logic [WADDR_W-1:0]      wr_idx;
  logic [WORD_W-1:0]       wr_data;

  function automatic logic [2:0] region_of(input logic [ADDR_W-1:0] a);
    return a[REGION_MSB:REGION_LSB];
  endfunction

  logic [2:0]   req_region;
  logic         locked;
  logic         hidden;
  logic         modify;
  logic         refuse;

  assign req_region = region_of(i_req.addr);
  assign locked     = i_read_only[req_region] | i_exec_only[req_region];
  assign hidden     = i_exec_only[req_region] & (i_req.op == FBP_OP_READ);
  assign modify     = (i_req.op == FBP_OP_PROG) | (i_req.op == FBP_OP_ERASE);
  // src is never checked: a fetch op from any port is served, and a read from any port is a data read
  assign refuse     = (modify & locked) | hidden;
  assign o_req_ready = (state == FBP_IDLE);
  assign o_rsp       = rsp;

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    next_state      = state;
    next_erase_cnt  = erase_cnt;
    next_erase_base = erase_base;
    next_rsp        = '0;
    next_rsp.rdata  = rsp.rdata;
    wr_en           = 1'b0;
    wr_idx          = i_req.addr[ADDR_W-1:2];
    wr_data         = i_req.wdata;
    unique case (state)
      FBP_IDLE: begin
        if (i_req_valid) begin
          if (refuse) begin
            next_rsp.done   = 1'b1;
            next_rsp.denied = 1'b1;
            next_rsp.rdata  = '0;
          end else if (i_req.op == FBP_OP_ERASE) begin
            // unit base only, so neighbours are never touched
            next_erase_base = {i_req.addr[ADDR_W-1:UNIT_LSB], 8'h00};
            next_erase_cnt  = '0;
            next_state      = FBP_ERASE;
          end else if (i_req.op == FBP_OP_PROG) begin
            // programming only clears bits, as real flash cells do
            wr_en         = 1'b1;
            wr_data       = mem[wr_idx] & i_req.wdata;
            next_rsp.done = 1'b1;
          end else begin
            next_rsp.done  = 1'b1;
            next_rsp.rdata = mem[i_req.addr[ADDR_W-1:2]];
          end
        end
      end
      FBP_ERASE: begin
        // one word per cycle: slow, but no wide write port
        wr_en   = 1'b1;
        wr_idx  = erase_base | WADDR_W'(erase_cnt);
        wr_data = ERASED_WORD;
        next_erase_cnt = erase_cnt + 8'h01;
        if (erase_cnt == 8'(UNIT_WORDS - 1)) begin
          next_state    = FBP_RESP;
        end
      end
      FBP_RESP: begin
        next_rsp.done = 1'b1;
        next_state    = FBP_IDLE;
      end
      default: begin
        next_state = FBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state      <= FBP_IDLE;
      erase_cnt  <= '0;
      erase_base <= '0;
      rsp        <= '0;
    end else begin
      state      <= next_state;
      erase_cnt  <= next_erase_cnt;
      erase_base <= next_erase_base;
      rsp        <= next_rsp;
    end
  end

  // array has no reset; contents are nonvolatile in spirit
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_locked_modify_denied;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && modify && i_read_only[req_region])
      |=> (o_rsp.done && o_rsp.denied);
  endproperty
  a_locked_modify_denied: assert property (p_locked_modify_denied) else $error("ro modify not denied");

  property p_xo_modify_denied;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && modify && i_exec_only[req_region])
      |=> (o_rsp.denied && o_req_ready);
  endproperty
  a_xo_modify_denied: assert property (p_xo_modify_denied) else $error("xo modify not denied");

  property p_xo_read_hidden;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && i_req.op == FBP_OP_READ && i_exec_only[req_region])
      |=> (o_rsp.denied && o_rsp.rdata == '0);
  endproperty
  a_xo_read_hidden: assert property (p_xo_read_hidden) else $error("xo read leaked");

  property p_fetch_served;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && i_req.op == FBP_OP_FETCH)
      |=> (o_rsp.done && !o_rsp.denied);
  endproperty
  a_fetch_served: assert property (p_fetch_served) else $error("fetch refused");

  property p_erase_length;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && i_req.op == FBP_OP_ERASE && !locked)
      |=> (!o_req_ready && !o_rsp.done) ##255 (state == FBP_ERASE) ##1 (state == FBP_RESP)
      ##1 o_rsp.done;
  endproperty
  a_erase_length: assert property (p_erase_length) else $error("erase length wrong");

  property p_erase_ones;
    @(posedge i_clk) disable iff (!i_resetn)
    (state == FBP_ERASE) |-> (wr_en && wr_data == ERASED_WORD
      && wr_idx[WADDR_W-1:UNIT_LSB-2] == erase_base[WADDR_W-1:UNIT_LSB-2]);
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase wrote outside unit");

  // a program to a pair whose own two bits are clear must land
  property p_region_select;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && i_req.op == FBP_OP_PROG
      && !i_read_only[i_req.addr[REGION_MSB:REGION_LSB]]
      && !i_exec_only[i_req.addr[REGION_MSB:REGION_LSB]])
      |=> (o_rsp.done && !o_rsp.denied);
  endproperty
  a_region_select: assert property (p_region_select) else $error("region select wrong");

  property p_read_data;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && !hidden
      && (i_req.op == FBP_OP_READ || i_req.op == FBP_OP_FETCH))
      |=> (o_rsp.rdata == $past(mem[i_req.addr[ADDR_W-1:2]]));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  // refused modify must not touch the array nor start an erase
  property p_ro_no_write;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && modify && i_read_only[i_req.addr[REGION_MSB:REGION_LSB]])
      |-> (!wr_en && next_state == FBP_IDLE);
  endproperty
  a_ro_no_write: assert property (p_ro_no_write) else $error("ro pair written");

  property p_xo_no_write;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && modify && i_exec_only[i_req.addr[REGION_MSB:REGION_LSB]])
      |-> (!wr_en && next_state == FBP_IDLE);
  endproperty
  a_xo_no_write: assert property (p_xo_no_write) else $error("xo pair written");

  // erase walk starts at the base of the addressed unit only
  property p_erase_base;
    @(posedge i_clk) disable iff (!i_resetn)
    (o_req_ready && i_req_valid && i_req.op == FBP_OP_ERASE && !locked)
      |=> (erase_base == {$past(i_req.addr[ADDR_W-1:UNIT_LSB]), 8'h00});
  endproperty
  a_erase_base: assert property (p_erase_base) else $error("erase base wrong");

endmodule

// >>> shared/fbp_pkg.sv
package fbp_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int FLASH_BYTES  = 16384;
  localparam int ADDR_W       = 14;
  localparam int WORD_W       = 32;
  localparam int WADDR_W      = 12;
  localparam int WORDS        = FLASH_BYTES / 4;
  localparam int UNIT_BYTES   = 1024;
  localparam int UNIT_WORDS   = UNIT_BYTES / 4;
  localparam int UNIT_LSB     = 10;
  localparam int UNITS        = FLASH_BYTES / UNIT_BYTES;
  localparam int REGION_LSB   = 11;
  localparam int REGION_MSB   = 13;
  localparam int REGIONS      = 8;
  localparam logic [WORD_W-1:0] ERASED_WORD = 32'hFFFFFFFF;

  // ****************************************
  // access kinds
  // ****************************************
  typedef enum logic [2:0] {
    FBP_OP_FETCH = 3'h0,
    FBP_OP_READ  = 3'h1,
    FBP_OP_PROG  = 3'h2,
    FBP_OP_ERASE = 3'h3
  } fbp_op_e;

  typedef enum logic [1:0] {
    FBP_SRC_FETCH = 2'h0,
    FBP_SRC_DATA  = 2'h1,
    FBP_SRC_DEBUG = 2'h2
  } fbp_src_e;

  typedef struct packed {
    fbp_op_e             op;
    fbp_src_e            src;
    logic [ADDR_W-1:0]   addr;
    logic [WORD_W-1:0]   wdata;
  } fbp_req_s;

  typedef struct packed {
    logic                done;
    logic                denied;
    logic [WORD_W-1:0]   rdata;
  } fbp_rsp_s;

  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    FBP_IDLE  = 2'b00,
    FBP_ERASE = 2'b01,
    FBP_RESP  = 2'b11
  } fbp_state_e;

endpackage

// >>> tb/fbp_host_model.sv
`timescale 1ns/1ps
module fbp_host_model
  import fbp_pkg::*;
(
  // clock
  input  wire logic     i_clk,
  // answer side
  input  wire logic     i_ready,
  input  wire fbp_rsp_s i_rsp,
  // request side
  output logic          o_valid,
  output fbp_req_s      o_req
);
  initial begin
    o_valid = 1'b0;
    o_req   = '0;
  end
  // ****************************************
  // one access
  // ****************************************
  task automatic access(input fbp_op_e op, input fbp_src_e src, input logic [ADDR_W-1:0] a,
      input logic [WORD_W-1:0] wd, output fbp_rsp_s rsp, output int lat);
    @(negedge i_clk);
    o_valid = 1'b1;
    o_req   = '{op, src, a, wd};
    // ready only moves on rising edges, so a falling-edge look is race free
    while (i_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    // latency counts from the accepting edge
    lat     = 1;
    o_valid = 1'b0;
    o_req   = ~o_req;
    while (i_rsp.done !== 1'b1 && lat < 400) begin
      @(negedge i_clk);
      lat++;
    end
    rsp = i_rsp;
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fbp_pkg::*;
  logic               i_clk;
  logic               i_resetn;
  logic               valid;
  logic               ready;
  logic [REGIONS-1:0] ro;
  logic [REGIONS-1:0] xo;
  fbp_req_s           req;
  fbp_rsp_s           rsp_w;
  fbp_rsp_s           rsp;
  logic [WORD_W-1:0]  mem [WORDS];
  int                 err_count;
  int                 n_tests;
  int                 lat;
  logic [31:0]        seed;
  fbp_flash_block_protection i_fbp_flash_block_protection (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_read_only(ro), .i_exec_only(xo), .i_req_valid(valid),
    .i_req(req), .o_req_ready(ready), .o_rsp(rsp_w));
  fbp_host_model i_fbp_host_model (.i_clk(i_clk), .i_ready(ready), .i_rsp(rsp_w),
    .o_valid(valid), .o_req(req));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic acc(input fbp_op_e op, input fbp_src_e src, input logic [13:0] a,
      input logic [31:0] wd);
    logic dn;
    int   w;
    w  = a[13:2];
    dn = (op inside {FBP_OP_PROG, FBP_OP_ERASE} && (ro[a[13:11]] || xo[a[13:11]]))
      || (op == FBP_OP_READ && xo[a[13:11]]);
    i_fbp_host_model.access(op, src, a, wd, rsp, lat);
    cmp(rsp.denied, dn);
    cmp(lat, (op == FBP_OP_ERASE && !dn) ? 258 : 1);
    if (dn || op inside {FBP_OP_FETCH, FBP_OP_READ})
      cmp(rsp.rdata, dn ? 32'h0 : mem[w]);
    if (!dn && op == FBP_OP_PROG) mem[w] &= wd;
    if (!dn && op == FBP_OP_ERASE)
      for (int i = 0; i < 256; i++) mem[{a[13:10], i[7:0]}] = ERASED_WORD;
  endtask
  task automatic do_reset();
    i_resetn = 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    // while held: idle and ready, no answer pending
    cmp({29'h0, ready, rsp_w.done, rsp_w.denied}, 32'h4);
    cmp(rsp_w.rdata, 32'h0);
    i_resetn = 1'b1;
  endtask
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #1000000;
    err_count++;
    results();
  end
  initial begin
    seed      = 32'hE950;
    ro        = '0;
    xo        = '0;
    err_count = 0;
    n_tests   = 0;
    do_reset();
    // array powers up unknown, so wipe every unit first
    for (int u = 0; u < UNITS; u++) acc(FBP_OP_ERASE, FBP_SRC_DATA, 14'(u * UNIT_BYTES), '0);
    for (int p = 0; p < 2; p++) begin
      // second pass follows a mid-run reset; the array keeps its contents
      if (p == 1) do_reset();
      for (int k = 0; k < 200; k++) begin
        // sparse locks so that many writes still land
        ro = 8'(rnd() & rnd());
        xo = 8'(rnd() & rnd() & rnd());
        acc(fbp_op_e'(3'(rnd() % 4)), fbp_src_e'(2'(rnd() % 3)), 14'(rnd()), rnd());
      end
    end
    results();
  end
endmodule
